// >>> core/dpc_buf2.sv
// Small valid/ready FIFO on the inbound data path
`timescale 1ns/1ns
`default_nettype none
module dpc_buf2 #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Fill side
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// Drain side
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse shapes the pointers cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_chk
		$error("dpc_buf2: DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	// Handshakes and honest full/empty
	assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			if (push & ~pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop & ~push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/dpc_core.sv
// DMA port configuration, transfer byte counter and handshake engine
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module dpc_core #(
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic          SYS_CLK_I,
	input  wire logic          RST_I,
	// APB slave
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [7:0]    PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	input  wire logic [3:0]    PSTRB_I,
	output logic [31:0]        PRDATA_O,
	output logic               PREADY_O,
	output logic               PSLVERR_O,
	// Command side
	input  wire logic          PIO_ACTIVE_I,
	input  wire logic [7:0]    STROBE_CYC_I,
	output logic               DISK_PROTOCOL_SELECT_O,
	output logic [2:0]         PROGRAMMED_IO_TIMING_SELECT_O,
	output logic               WIDTH16_O,
	// DMA pins, slave-mode strobes in
	input  wire logic          DEVICE_READ_STROBE_I,
	input  wire logic          DEVICE_WRITE_STROBE_I,
	input  wire logic          DMA_ACKNOWLEDGE_I,
	// DMA pins, master-mode strobes out
	output logic               DEVICE_READ_STROBE_O,
	output logic               DEVICE_WRITE_STROBE_O,
	output logic               DMA_ACKNOWLEDGE_O,
	// DMA request pin
	output logic               DMA_REQUEST_O,
	output logic               DMA_REQUEST_OE_N_O,
	// DMA data pins
	input  wire logic [DW-1:0] DATA_I,
	output logic [DW-1:0]      DATA_O,
	output logic               DATA_OE_N_O,
	// Inbound stream to the endpoint side
	output logic [DW-1:0]      RX_DATA_O,
	output logic               RX_VALID_O,
	input  wire logic          RX_READY_I,
	// Outbound stream from the endpoint side
	input  wire logic [DW-1:0] TX_DATA_I,
	input  wire logic          TX_VALID_I,
	output logic               TX_READY_O
);
	// Width check
	if (DW != 16) begin : g_chk
		$error("dpc_core: DW must be 16");
	end

	typedef enum {M_IDLE, M_STROBE, M_RECOV} dpc_mst_t;

	logic [15:0]         cfg_ff;
	logic [7:0]          hw_ff;
	logic [31:0]         cnt_ff;
	logic [31:0]         nxt_cnt;
	logic [31:0]         prdata_ff;
	logic [31:0]         rd_val;
	logic [31:0]         wmask;
	logic [DW+2:0]       sync1_ff;
	logic [DW+2:0]       sync2_ff;
	logic [DW-1:0]       dout_ff;
	logic [DW-1:0]       rx_word;
	logic [7:0]          tmr_ff;
	logic [7:0]          stb_len;
	logic [7:0]          step;
	logic                cfg_seen_ff;
	logic                stb_prev_ff;
	logic                req_ff;
	logic                mst;
	logic                inbound;
	logic                apb_acc;
	logic                apb_hit;
	logic                cfg_wr;
	logic                hw_wr;
	logic                cnt_wr;
	logic                cnt_en;
	logic                run;
	logic                w16_eff;
	logic                src_ok;
	logic                stb_lvl;
	logic                xfer;
	logic                buf_in_ready;
	logic                mend_ff;
	logic                mtake_ff;
	dpc_mst_t            st_ff;
	dpc_pkg::dpc_cfg_t   cfg;
	dpc_pkg::dpc_stb_t   stb_sel;

	// Strobe line that carries data for the mapping, mode and direction
	function automatic dpc_pkg::dpc_stb_t sel_stb(input logic [1:0] map, input logic m, input logic inb);
		if (map == dpc_pkg::MAP_STD) begin
			return (m == inb) ? dpc_pkg::STB_READ : dpc_pkg::STB_WRITE;
		end else if (map == dpc_pkg::MAP_RDACK) begin
			if (inb) begin
				return m ? dpc_pkg::STB_READ : dpc_pkg::STB_ACK;
			end
			return m ? dpc_pkg::STB_ACK : dpc_pkg::STB_READ;
		end
		return dpc_pkg::STB_ACK;
	endfunction

	// Byte-lane write mask from the strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// Field decode
	always_comb begin
		cfg.ata = cfg_ff[dpc_pkg::ATA_BIT];
		cfg.mt  = cfg_ff[dpc_pkg::MT_LSB +: 2];
		cfg.pio = cfg_ff[dpc_pkg::PIO_LSB +: 3];
		cfg.dis = cfg_ff[dpc_pkg::DIS_BIT];
		cfg.map = cfg_ff[dpc_pkg::MAP_LSB +: 2];
		cfg.w16 = cfg_ff[dpc_pkg::WID_BIT];
	end

	// Mode and gating terms
	assign mst     = hw_ff[dpc_pkg::MST_BIT];
	assign inbound = ~hw_ff[dpc_pkg::DIR_BIT];
	assign cnt_en  = mst | ~cfg.dis;
	assign run     = ~cnt_en | (cnt_ff != dpc_pkg::CNT_RST);
	assign w16_eff = cfg.w16 | PIO_ACTIVE_I;
	assign step    = w16_eff ? 8'h02 : 8'h01;
	assign src_ok  = inbound ? buf_in_ready : TX_VALID_I;
	assign stb_sel = sel_stb(cfg.map, mst, inbound);
	assign stb_lvl = sync2_ff[stb_sel];

	// Status towards the command side
	assign DISK_PROTOCOL_SELECT_O        = cfg.ata;
	assign PROGRAMMED_IO_TIMING_SELECT_O = cfg.pio;
	assign WIDTH16_O                     = cfg.w16;

	// APB decode, zero wait states
	assign apb_acc   = PSEL_I & PENABLE_I;
	assign apb_hit   = (PADDR_I == dpc_pkg::CNT_OFS) | (PADDR_I == dpc_pkg::CFG_OFS) | (PADDR_I == dpc_pkg::HW_OFS);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = apb_acc & ~apb_hit;
	assign PRDATA_O  = prdata_ff;
	assign wmask     = lane_mask(PSTRB_I);
	assign cfg_wr    = apb_acc & PWRITE_I & (PADDR_I == dpc_pkg::CFG_OFS);
	assign hw_wr     = apb_acc & PWRITE_I & (PADDR_I == dpc_pkg::HW_OFS);
	assign cnt_wr    = apb_acc & PWRITE_I & (PADDR_I == dpc_pkg::CNT_OFS);

	// Read mux, reserved bits as zero
	always_comb begin
		rd_val = '0;
		if (PADDR_I == dpc_pkg::CNT_OFS) begin
			rd_val = cnt_ff;
		end else if (PADDR_I == dpc_pkg::CFG_OFS) begin
			rd_val[15:0] = cfg_ff & dpc_pkg::CFG_MASK;
		end else if (PADDR_I == dpc_pkg::HW_OFS) begin
			rd_val[7:0] = hw_ff;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			prdata_ff <= '0;
		end else if (PSEL_I & ~PENABLE_I) begin
			prdata_ff <= rd_val;
		end
	end

	// Configuration register, reserved bits kept at zero
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cfg_ff <= dpc_pkg::CFG_RST;
		end else if (cfg_wr) begin
			cfg_ff <= (cfg_ff & ~(wmask[15:0] & dpc_pkg::CFG_MASK)) | (PWDATA_I[15:0] & wmask[15:0] & dpc_pkg::CFG_MASK);
		end
	end

	// Mode control register
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			hw_ff <= dpc_pkg::HW_RST;
		end else if (hw_wr & PSTRB_I[0]) begin
			hw_ff <= PWDATA_I[7:0] & dpc_pkg::HW_MASK;
		end
	end

	// First configuration write unlocks the request pin
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cfg_seen_ff <= 1'b0;
		end else if (cfg_wr) begin
			cfg_seen_ff <= 1'b1;
		end
	end

	// Counter next value: lane writes win over the decrement
	always_comb begin
		nxt_cnt = cnt_ff;
		if (xfer) begin
			if (cnt_en && cnt_ff < {24'h00_0000, step}) begin
				nxt_cnt = dpc_pkg::CNT_RST;
			end else begin
				nxt_cnt = cnt_ff - {24'h00_0000, step};
			end
		end
		if (cnt_wr) begin
			nxt_cnt = (nxt_cnt & ~wmask) | (PWDATA_I & wmask);
		end
	end

	// Transfer byte counter
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cnt_ff <= dpc_pkg::CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Two-stage synchroniser for pin strobes and data
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {DATA_I, DMA_ACKNOWLEDGE_I, DEVICE_WRITE_STROBE_I, DEVICE_READ_STROBE_I};
			sync2_ff <= sync1_ff;
		end
	end

	// Edge history of the chosen strobe
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			stb_prev_ff <= 1'b0;
		end else begin
			stb_prev_ff <= stb_lvl;
		end
	end

	// Strobe length per timing mode
	always_comb begin
		if (PIO_ACTIVE_I) begin
			stb_len = dpc_pkg::ns2cyc(dpc_pkg::PIO_NS[(cfg.pio > dpc_pkg::PIO_TOP) ? 3'h0 : cfg.pio]);
		end else if (cfg.mt == dpc_pkg::MT_PROG) begin
			stb_len = (STROBE_CYC_I == 8'h00) ? 8'h01 : STROBE_CYC_I;
		end else begin
			stb_len = dpc_pkg::ns2cyc(dpc_pkg::MSTR_NS[cfg.mt]);
		end
	end

	// Master-mode strobe sequencer
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			st_ff  <= M_IDLE;
			tmr_ff <= 8'h00;
		end else begin
			unique case (st_ff)
				M_IDLE: begin
					if (mst & run & src_ok & ~mend_ff & ~mtake_ff) begin
						st_ff  <= M_STROBE;
						tmr_ff <= stb_len;
					end
				end
				M_STROBE: begin
					if (tmr_ff == 8'h01) begin
						st_ff  <= M_RECOV;
						tmr_ff <= stb_len;
					end else begin
						tmr_ff <= tmr_ff - 8'h01;
					end
				end
				M_RECOV: begin
					if (tmr_ff == 8'h01) begin
						st_ff <= M_IDLE;
					end else begin
						tmr_ff <= tmr_ff - 8'h01;
					end
				end
			endcase
		end
	end

	// Inbound master word waits two edges so its data has cleared the synchroniser
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			mend_ff  <= 1'b0;
			mtake_ff <= 1'b0;
		end else begin
			mend_ff  <= mst & inbound & (st_ff == M_STROBE) & (tmr_ff == 8'h01) & buf_in_ready;
			mtake_ff <= mend_ff;
		end
	end

	// One word moved: end of master strobe, or slave strobe edge
	always_comb begin
		if (mst) begin
			xfer = inbound ? mtake_ff : ((st_ff == M_STROBE) && (tmr_ff == 8'h01) && TX_VALID_I);
		end else if (inbound) begin
			xfer = run & stb_lvl & ~stb_prev_ff & buf_in_ready;
		end else begin
			xfer = run & ~stb_lvl & stb_prev_ff & TX_VALID_I;
		end
	end

	// Master strobes on the mapped line
	assign DEVICE_READ_STROBE_O  = (st_ff == M_STROBE) && (stb_sel == dpc_pkg::STB_READ);
	assign DEVICE_WRITE_STROBE_O = (st_ff == M_STROBE) && (stb_sel == dpc_pkg::STB_WRITE);
	assign DMA_ACKNOWLEDGE_O     = (st_ff == M_STROBE) && (stb_sel == dpc_pkg::STB_ACK);

	// Slave request, held undriven until configured
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			req_ff <= 1'b0;
		end else begin
			req_ff <= ~mst & run & src_ok & cfg_seen_ff;
		end
	end
	assign DMA_REQUEST_O      = req_ff;
	assign DMA_REQUEST_OE_N_O = ~cfg_seen_ff;

	// Outbound data register and drive window
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			dout_ff <= '0;
		end else begin
			dout_ff <= w16_eff ? TX_DATA_I : {8'h00, TX_DATA_I[7:0]};
		end
	end
	assign DATA_O      = dout_ff;
	assign DATA_OE_N_O = ~(~inbound & (mst ? (st_ff == M_STROBE) : stb_lvl));
	assign TX_READY_O  = xfer & ~inbound;

	// Inbound word, low byte only on an 8-bit bus
	assign rx_word = w16_eff ? sync2_ff[DW+2:3] : {8'h00, sync2_ff[10:3]};

	// Two-entry buffer towards the endpoint side
	dpc_buf2 #(
		.W     (DW),
		.DEPTH (2)
	) u_buf (
		.clk_i       (SYS_CLK_I),
		.rst_i       (RST_I),
		.in_data_i   (rx_word),
		.in_valid_i  (xfer & inbound),
		.in_ready_o  (buf_in_ready),
		.out_data_o  (RX_DATA_O),
		.out_valid_o (RX_VALID_O),
		.out_ready_i (RX_READY_I)
	);

	// Checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	req_undriven_a: assert property (!cfg_seen_ff |-> DMA_REQUEST_OE_N_O && !DMA_REQUEST_O)
		else $error("request pin driven before configuration");
	width_reset_a: assert property ($past(RST_I) |-> WIDTH16_O)
		else $error("width bit not 16-bit after reset");
	cnt_dec_a: assert property (xfer && !cnt_wr && !cnt_en |=> cnt_ff == $past(cnt_ff) - {24'h00_0000, $past(step)})
		else $error("disabled counter did not decrement by the step");
	cnt_hold_a: assert property (mst && cnt_ff == '0 && !cnt_wr |=> cnt_ff == '0 && st_ff != M_STROBE)
		else $error("master counter moved past zero");
	pio_wide_a: assert property (PIO_ACTIVE_I |-> step == 8'h02)
		else $error("programmed-I/O word not 16-bit");
	ack_only_a: assert property (st_ff == M_STROBE && cfg.map == 2'h2 |-> DMA_ACKNOWLEDGE_O && !DEVICE_READ_STROBE_O && !DEVICE_WRITE_STROBE_O)
		else $error("mapping 10 did not use acknowledge alone");
	slave_map_a: assert property (!mst && inbound && cfg.map == dpc_pkg::MAP_STD |-> stb_sel == dpc_pkg::STB_WRITE)
		else $error("slave inbound not on write strobe");
	slave_ack_a: assert property (!mst && inbound && cfg.map == dpc_pkg::MAP_RDACK |-> stb_sel == dpc_pkg::STB_ACK)
		else $error("slave inbound not on acknowledge");
	mdma0_len_a: assert property (st_ff == M_IDLE && !PIO_ACTIVE_I && cfg.mt == 2'h0 ##1 st_ff == M_STROBE
		|-> (st_ff == M_STROBE)[*4] ##1 st_ff == M_RECOV)
		else $error("timing mode 0 strobe length wrong");
	prog_len_a: assert property (st_ff == M_IDLE && !PIO_ACTIVE_I && cfg.mt == dpc_pkg::MT_PROG && STROBE_CYC_I != 8'h00
		##1 st_ff == M_STROBE |-> tmr_ff == $past(STROBE_CYC_I))
		else $error("programmable strobe length not taken");
	ata_sel_a: assert property (cfg_wr && PSTRB_I[1] |=> DISK_PROTOCOL_SELECT_O == $past(PWDATA_I[13]))
		else $error("protocol select not following bit 13");
	lane_wr_a: assert property (cnt_wr && PSTRB_I == 4'h8 && !xfer |=> cnt_ff[31:24] == $past(PWDATA_I[31:24])
		&& cnt_ff[23:0] == $past(cnt_ff[23:0]))
		else $error("top counter lane write disturbed other lanes");

	slave_in_c: cover property (!mst && inbound && xfer);
	master_out_c: cover property (mst && !inbound && xfer);
	buf_full_c: cover property (!buf_in_ready ##1 RX_READY_I);
	roll_c: cover property (!cnt_en && xfer && cnt_ff == '0);
endmodule
`default_nettype wire

// >>> core/dpc_pkg.sv
// Package: offsets, fields, codes and timing of the DMA port configuration block
package dpc_pkg;
	// Register byte offsets
	localparam logic [7:0]  CNT_OFS  = 8'h34;
	localparam logic [7:0]  CFG_OFS  = 8'h38;
	localparam logic [7:0]  HW_OFS   = 8'h3C;
	// Configuration register fields
	localparam int          ATA_BIT  = 13;
	localparam int          MT_LSB   = 11;
	localparam int          PIO_LSB  = 8;
	localparam int          DIS_BIT  = 7;
	localparam int          MAP_LSB  = 2;
	localparam int          WID_BIT  = 0;
	localparam logic [15:0] CFG_RST  = 16'h0001;
	localparam logic [15:0] CFG_MASK = 16'h3F8D;
	// Mode control register fields
	localparam int          MST_BIT  = 4;
	localparam int          DIR_BIT  = 0;
	localparam logic [7:0]  HW_RST   = 8'h00;
	localparam logic [7:0]  HW_MASK  = 8'h11;
	localparam logic [31:0] CNT_RST  = 32'h0000_0000;
	// Field codes
	localparam logic [1:0]  MAP_STD   = 2'h0;
	localparam logic [1:0]  MAP_RDACK = 2'h1;
	localparam logic [1:0]  MT_PROG   = 2'h3;
	localparam logic [2:0]  PIO_TOP   = 3'h4;
	// Strobe times in ns per timing mode
	localparam int          CLK_NS   = 50;
	localparam int          MSTR_NS [3] = '{200, 150, 100};
	localparam int          PIO_NS  [5] = '{400, 300, 250, 200, 150};

	// Least time to whole cycles, never under one
	function automatic logic [7:0] ns2cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 8'h01 : c[7:0];
	endfunction

	// Handshake line chosen for the data strobe
	typedef enum logic [1:0] {STB_READ, STB_WRITE, STB_ACK} dpc_stb_t;

	// Decoded configuration fields
	typedef struct packed {
		logic       ata;
		logic [1:0] mt;
		logic [2:0] pio;
		logic       dis;
		logic [1:0] map;
		logic       w16;
	} dpc_cfg_t;
endpackage

// >>> sim/dpc_core_tb.sv
// Self-checking testbench of the DMA port configuration block
`timescale 1ns/1ns
`default_nettype none
module dpc_core_tb;
	localparam logic [7:0]  cnt_a = dpc_pkg::CNT_OFS;
	localparam logic [7:0]  cfg_a = dpc_pkg::CFG_OFS;
	localparam logic [7:0]  hw_a  = dpc_pkg::HW_OFS;
	localparam int          bad  [3] = '{2, 0, 0};
	localparam int          good [3] = '{0, 1, 1};
	localparam logic [15:0] mcfg [8] = '{16'h2081, 16'h2881, 16'h3081, 16'h3881,
		16'h2080, 16'h2180, 16'h2280, 16'h2480};
	localparam int          mlen [8] = '{4, 3, 2, 5, 8, 6, 5, 3};
	logic        clk, rst, psel, pen, pwr, pio, rxr, txv, err;
	logic [7:0]  paddr;
	logic [31:0] pwd, prd, prdata;
	logic [3:0]  pstrb;
	logic [15:0] txd, dato, dati, rxd;
	logic        pready, pslverr, proto, w16, rdo, req, oe_n, rxv, rdi, wri, acki;
	logic        txr, doe_n, wro, acko;
	logic [2:0]  piosel;
	int          checks, mismatches, cyc, txn, oen, ackn, wrn;

	dpc_core dpc_core_inst (
		.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(pstrb), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PIO_ACTIVE_I(pio), .STROBE_CYC_I(8'h05),
		.DISK_PROTOCOL_SELECT_O(proto), .PROGRAMMED_IO_TIMING_SELECT_O(piosel),
		.WIDTH16_O(w16), .DEVICE_READ_STROBE_I(rdi), .DEVICE_WRITE_STROBE_I(wri),
		.DMA_ACKNOWLEDGE_I(acki), .DEVICE_READ_STROBE_O(rdo), .DEVICE_WRITE_STROBE_O(wro),
		.DMA_ACKNOWLEDGE_O(acko), .DMA_REQUEST_O(req), .DMA_REQUEST_OE_N_O(oe_n),
		.DATA_I(dati), .DATA_O(dato), .DATA_OE_N_O(doe_n), .RX_DATA_O(rxd), .RX_VALID_O(rxv),
		.RX_READY_I(rxr), .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_READY_O(txr)
	);

	dpc_peer dpc_peer_inst (
		.clk_i(clk), .req_i(req), .mrd_i(rdo), .dat_i(dato),
		.rd_o(rdi), .wr_o(wri), .ack_o(acki), .dat_o(dati)
	);

	// Clock, hang guard and pin activity counts
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		txn += int'(txr === 1'b1);
		oen += int'(doe_n === 1'b0);
		ackn += int'(acko === 1'b1);
		wrn += int'(wro === 1'b1);
		if (cyc == 20000) begin
			mismatches++;
			finish_test;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// One APB transfer; waits for the ready answer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		prd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(prd, e);
	endtask

	task automatic setup(input logic [15:0] c, input logic [7:0] h, input logic [31:0] n);
		apb(1'b1, cnt_a, 32'h0, 4'hF);
		apb(1'b1, hw_a, 32'(h), 4'h1);
		apb(1'b1, cfg_a, 32'(c), 4'h3);
		apb(1'b1, cnt_a, n, 4'hF);
	endtask

	// Takes one inbound word and compares it
	task automatic drain(input logic [15:0] e);
		@(posedge clk);
		while (rxv !== 1'b1) begin
			@(posedge clk);
		end
		chk(32'(rxd), 32'(e));
		rxr <= 1'b1;
		@(posedge clk);
		rxr <= 1'b0;
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{clk, psel, pen, pwr, pio, rxr, txv, err} = 8'h00;
		{paddr, pwd, pstrb, txd, prd} = '0;
		{checks, mismatches, cyc, txn, oen, ackn, wrn} = '0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdchk(cfg_a, 32'h1);
		rdchk(cnt_a, 32'h0);
		chk(32'(oe_n), 32'h1);
		$display("test reset done");
		apb(1'b1, cfg_a, 32'hC0F2, 4'h3);
		rdchk(cfg_a, 32'h80);
		chk(32'(oe_n), 32'h0);
		apb(1'b1, cfg_a, 32'h2300, 4'h3);
		rdchk(cfg_a, 32'h2300);
		chk(32'(proto), 32'h1);
		chk(32'(piosel), 32'h3);
		apb(1'b1, cfg_a, 32'h0, 4'h3);
		rdchk(cfg_a, 32'h0);
		chk(32'({proto, w16}), 32'h0);
		apb(1'b1, cnt_a, 32'hAABBCCDD, 4'hF);
		apb(1'b1, cnt_a, 32'h11223344, 4'hA);
		rdchk(cnt_a, 32'h11BB33DD);
		apb(1'b1, cnt_a, 32'h99000000, 4'h8);
		rdchk(cnt_a, 32'h99BB33DD);
		apb(1'b1, 8'h40, 32'hFFFF, 4'hF);
		chk(32'(err), 32'h1);
		rdchk(8'h40, 32'h0);
		$display("test registers done");
		for (int m = 0; m < 3; m++) begin
			setup(16'h0001 | 16'(m << 2), 8'h00, 32'h6);
			dpc_peer_inst.send(bad[m], 16'h5A00);
			dpc_peer_inst.send(good[m], 16'h1230 + 16'(m));
			drain(16'h1230 + 16'(m));
			rdchk(cnt_a, 32'h4);
		end
		$display("test slave mapping done");
		setup(16'h0000, 8'h00, 32'h1);
		dpc_peer_inst.send(0, 16'hA55A);
		drain(16'h005A);
		rdchk(cnt_a, 32'h0);
		chk(32'(req), 32'h0);
		$display("test narrow done");
		setup(16'h0081, 8'h00, 32'h0);
		dpc_peer_inst.send(0, 16'h7777);
		drain(16'h7777);
		rdchk(cnt_a, 32'hFFFFFFFE);
		$display("test wrap done");
		setup(16'h0001, 8'h00, 32'hA);
		dpc_peer_inst.send(0, 16'h1111);
		dpc_peer_inst.send(0, 16'h2222);
		repeat (6) @(posedge clk);
		chk(32'(req), 32'h0);
		drain(16'h1111);
		drain(16'h2222);
		rdchk(cnt_a, 32'h6);
		$display("test buffer done");
		setup(16'h0001, 8'h01, 32'h4);
		txd <= 16'hBEEF;
		txv <= 1'b1;
		dpc_peer_inst.send(2, 16'h0000);
		txv <= 1'b0;
		chk(32'(dpc_peer_inst.got), 32'hBEEF);
		chk(32'(txn), 32'h1);
		chk(32'(oen), 32'h5);
		rdchk(cnt_a, 32'h2);
		$display("test outbound done");
		for (int i = 0; i < 8; i++) begin
			pio <= (i > 3);
			setup(mcfg[i], 8'h10, 32'h2);
			drain(16'hC3A5);
			chk(32'(dpc_peer_inst.len), 32'(mlen[i]));
			rdchk(cnt_a, 32'h0);
		end
		$display("test master done");
		pio <= 1'b0;
		txd <= 16'h5AA5;
		txv <= 1'b1;
		setup(16'h2009, 8'h11, 32'h2);
		repeat (20) @(posedge clk);
		txv <= 1'b0;
		chk(32'(ackn), 32'h4);
		chk(32'(wrn), 32'h0);
		chk(32'(oen), 32'h9);
		chk(32'(txn), 32'h2);
		rdchk(cnt_a, 32'h0);
		$display("test master outbound done");
		finish_test;
	end
endmodule
`default_nettype wire

// >>> sim/dpc_peer.sv
// Behavioural external DMA controller and drive facing the DMA port
`timescale 1ns/1ns
`default_nettype none
module dpc_peer (
	// Clock
	input  wire logic        clk_i,
	// From the device
	input  wire logic        req_i,
	input  wire logic        mrd_i,
	input  wire logic [15:0] dat_i,
	// To the device
	output logic             rd_o,
	output logic             wr_o,
	output logic             ack_o,
	output logic [15:0]      dat_o
);
	logic [15:0] sdat;
	logic [15:0] mdat;
	logic [15:0] got;
	int          hi = 0;
	int          len = 0;

	// Drive answers the master read strobe, else slave data
	assign dat_o = mrd_i ? mdat : sdat;

	// Length of the last master read strobe
	always @(posedge clk_i) begin
		if (mrd_i) begin
			hi <= hi + 1;
		end else if (hi != 0) begin
			len <= hi;
			hi <= 0;
		end
	end

	// Idle pins at time zero
	initial begin
		sdat = 16'h0000;
		mdat = 16'hC3A5;
		got = 16'h0000;
		{rd_o, ack_o, wr_o} = 3'h0;
	end

	// One word on strobe s: 0 write, 1 acknowledge, 2 read
	task automatic send(input int s, input logic [15:0] d);
		while (req_i !== 1'b1) begin
			@(posedge clk_i);
		end
		sdat <= d;
		repeat (2) @(posedge clk_i);
		{rd_o, ack_o, wr_o} <= 3'(1 << s);
		repeat (5) @(posedge clk_i);
		got <= dat_i;
		{rd_o, ack_o, wr_o} <= 3'h0;
		repeat (3) @(posedge clk_i);
		sdat <= ~d; // Released bus no longer shows the word
		repeat (2) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire
